//--- design/dtf_defs.svh
// Purpose: Named constants for the delay timer block
// Assumes: 40 MHz system clock, 32-bit AXI4-Lite data
// Notes: Offsets are byte addresses
`ifndef DTF_DEFS_SVH
`define DTF_DEFS_SVH

// Register byte offsets
`define DTF_OFF_CTRL 8'h00
`define DTF_OFF_HIGH_SPAN 8'h04
`define DTF_OFF_LOW_SPAN 8'h08
`define DTF_OFF_STATUS 8'h0c
`define DTF_OFF_ELAPSED 8'h10

// Control field positions
`define DTF_CTRL_MODE_LSB 0
`define DTF_CTRL_MODE_MSB 1
`define DTF_CTRL_INV_TRG 2
`define DTF_CTRL_INV_CLR 3
`define DTF_CTRL_RETAIN 4
`define DTF_CTRL_USE_VALUE 5
`define DTF_CTRL_TB_LSB 6
`define DTF_CTRL_TB_MSB 7
`define DTF_CTRL_UNIT_LSB 8
`define DTF_CTRL_UNIT_MSB 9
`define DTF_CTRL_SRC_LSB 10
`define DTF_CTRL_SRC_MSB 11
`define DTF_CTRL_WIDTH 12

// Reset values
`define DTF_CTRL_RESET 12'h000
`define DTF_SPAN_RESET 16'h0000

// Constant span word layout: major in high byte, minor in low byte
`define DTF_SPAN_MINOR_LSB 0
`define DTF_SPAN_MINOR_MSB 7
`define DTF_SPAN_MAJOR_LSB 8
`define DTF_SPAN_MAJOR_MSB 15

// Limits of the span sources
`define DTF_LIM_MS 32'd99990
`define DTF_LIM_S 32'd5999
`define DTF_LIM_MIN 32'd5999
`define DTF_CONST_MAJOR_MAX 32'd99
`define DTF_CONST_MINOR_MAX_S 32'd99
`define DTF_CONST_MINOR_MAX_MH 32'd59
`define DTF_MS_PER_TICK 32'd10
`define DTF_TICKS_PER_S 32'd100
`define DTF_S_PER_MIN 32'd60
`define DTF_TICKS_PER_MIN 32'd6000

// Timing
`define DTF_TICK_NS 10000000
`define DTF_CLK_NS 25

// Bus responses
`define DTF_RESP_OKAY 2'b00
`define DTF_RESP_SLVERR 2'b10

`endif

//--- design/dtf_delay_timer.sv
// Purpose: Configurable delay timer function with AXI4-Lite control
// Assumes: trg, clr and the actual values are synchronous to clk_sys
// Notes: One function instance; mode picked in the control register
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dtf_defs.svh"

// How it works
// - Referenced span timebase is ms up to 99990, s or min up to 5999.
// - Referenced values outside the range are clamped to the nearest valid value.
// - On-delay starts on rising trigger and sets output at span expiry.
// - On-delay clears elapsed count when trigger drops early, output stays low.
// - On-delay output is low whenever trigger is low.
// - Retain option keeps output and elapsed count across power loss.
// - Off-delay output rises at once with the trigger.
// - Off-delay falling trigger restarts count; output drops when count meets span.
// - Off-delay further trigger pulses restart the count from zero.
// - Off-delay clearing input clears count and output at any time.
// - On/off-delay rising trigger starts high delay; output set if held high.
// - On/off-delay early fall clears high-delay count, output unchanged.
// - On/off-delay falling trigger starts low delay; output cleared if held low.
// - On/off-delay early rise clears low-delay count, output stays high.
// - Latching on-delay sets output at span expiry even if trigger fell.
// - Latching on-delay ignores trigger once timing has started.
// - Latching on-delay is cleared only by clearing input or unretained power loss.
// - Span is a constant or a selected comparator, threshold, amplifier, counter value; on/off-delay uses constants only.
// - Constant span reaches 99:99 s, 99:59 m, 99:59 h at matching resolution.
// - Trigger and clearing inputs can each be inverted.
module dtf_delay_timer
  import dtf_pkg::*;
#(
  parameter int AW = 8,
  parameter int CW = 26,
  parameter int TICK_CYCLES = `DTF_TICK_NS / `DTF_CLK_NS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic trg,
  input wire logic clr,
  input wire logic pwr_loss,
  input wire logic signed [31:0] cmp_value,
  input wire logic signed [31:0] thr_value,
  input wire logic signed [31:0] amp_value,
  input wire logic signed [31:0] cnt_value,
  output logic q_out
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  // Register index decode; 0 marks an unmapped address
  function automatic logic [2:0] reg_sel(input logic [AW-1:0] addr);
    case (8'(addr))
      `DTF_OFF_CTRL: reg_sel = 3'h1;
      `DTF_OFF_HIGH_SPAN: reg_sel = 3'h2;
      `DTF_OFF_LOW_SPAN: reg_sel = 3'h3;
      `DTF_OFF_STATUS: reg_sel = 3'h4;
      `DTF_OFF_ELAPSED: reg_sel = 3'h5;
      default: reg_sel = 3'h0;
    endcase
  endfunction : reg_sel

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge_strb = res;
  endfunction : merge_strb

  logic [`DTF_CTRL_WIDTH-1:0] ctrl_q;
  logic [15:0] high_span_q;
  logic [15:0] low_span_q;
  logic awready_q;
  logic wready_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic do_write;

  logic [TW-1:0] tick_cnt_q;
  logic tick_q;
  logic trg_prev_q;
  dtf_state_e st_q;
  dtf_state_e st_d;
  logic q_q;
  logic q_d;
  logic phase_hi_q;
  logic phase_hi_d;
  logic [CW-1:0] elapsed_count_q;
  logic cnt_clr;

  dtf_mode_e mode;
  logic trg_e;
  logic clr_e;
  logic rise;
  logic fall;
  logic retain;
  logic signed [31:0] analog_value;
  logic [CW-1:0] high_delay;
  logic [CW-1:0] low_delay;
  logic [CW-1:0] span_cur;
  logic reached;

  assign mode = dtf_mode_e'(ctrl_q[`DTF_CTRL_MODE_MSB:`DTF_CTRL_MODE_LSB]);
  assign retain = ctrl_q[`DTF_CTRL_RETAIN];
  assign trg_e = trg ^ ctrl_q[`DTF_CTRL_INV_TRG];
  assign clr_e = clr ^ ctrl_q[`DTF_CTRL_INV_CLR];
  assign rise = trg_e & ~trg_prev_q;
  assign fall = ~trg_e & trg_prev_q;

  // AXI4-Lite write channel
  assign do_write = aw_hold_q & w_hold_q & ~bvalid_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      awready_q <= 1'b0;
      aw_hold_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_hold_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_q <= 1'b0;
    end else if (!aw_hold_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wready_q <= 1'b0;
      w_hold_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_hold_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold_q <= 1'b0;
    end else if (!w_hold_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= `DTF_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= (reg_sel(awaddr_q) == 3'h0) ? `DTF_RESP_SLVERR : `DTF_RESP_OKAY;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `DTF_CTRL_RESET;
      high_span_q <= `DTF_SPAN_RESET;
      low_span_q <= `DTF_SPAN_RESET;
    end else if (do_write) begin
      case (reg_sel(awaddr_q))
        3'h1: ctrl_q <= `DTF_CTRL_WIDTH'(merge_strb(32'(ctrl_q), wdata_q, wstrb_q));
        3'h2: high_span_q <= 16'(merge_strb(32'(high_span_q), wdata_q, wstrb_q));
        3'h3: low_span_q <= 16'(merge_strb(32'(low_span_q), wdata_q, wstrb_q));
        default: ;
      endcase
    end
  end

  // AXI4-Lite read channel, data one cycle after the address is taken
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `DTF_RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= `DTF_RESP_OKAY;
      case (reg_sel(s_axi_araddr))
        3'h1: rdata_q <= 32'(ctrl_q);
        3'h2: rdata_q <= 32'(high_span_q);
        3'h3: rdata_q <= 32'(low_span_q);
        3'h4: rdata_q <= {26'h0, phase_hi_q, st_q, trg_e, q_q};
        3'h5: rdata_q <= 32'(elapsed_count_q);
        default: begin
          rdata_q <= '0;
          rresp_q <= `DTF_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  // Span sources
  always_comb begin
    case (ctrl_q[`DTF_CTRL_SRC_MSB:`DTF_CTRL_SRC_LSB])
      2'h0: analog_value = cmp_value;
      2'h1: analog_value = thr_value;
      2'h2: analog_value = amp_value;
      default: analog_value = cnt_value;
    endcase
  end

  dtf_span_calc #(
    .CW(CW)
  ) u_high_span (
    .use_value(ctrl_q[`DTF_CTRL_USE_VALUE] && (mode != DTF_MODE_ONOFF)),
    .value_tb(ctrl_q[`DTF_CTRL_TB_MSB:`DTF_CTRL_TB_LSB]),
    .const_unit(ctrl_q[`DTF_CTRL_UNIT_MSB:`DTF_CTRL_UNIT_LSB]),
    .const_word(high_span_q),
    .analog_value(analog_value),
    .span_ticks(high_delay)
  );

  // Low delay is always a constant
  dtf_span_calc #(
    .CW(CW)
  ) u_low_span (
    .use_value(1'b0),
    .value_tb(ctrl_q[`DTF_CTRL_TB_MSB:`DTF_CTRL_TB_LSB]),
    .const_unit(ctrl_q[`DTF_CTRL_UNIT_MSB:`DTF_CTRL_UNIT_LSB]),
    .const_word(low_span_q),
    .analog_value(analog_value),
    .span_ticks(low_delay)
  );

  assign span_cur = (mode == DTF_MODE_ONOFF && !phase_hi_q) ? low_delay : high_delay;
  assign reached = (elapsed_count_q >= span_cur);

  // Common 10 ms tick
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TW'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + TW'(1);
      tick_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trg_prev_q <= 1'b0;
    end else begin
      trg_prev_q <= trg_e;
    end
  end

  // Timer behaviour per mode
  always_comb begin
    st_d = st_q;
    q_d = q_q;
    phase_hi_d = phase_hi_q;
    cnt_clr = 1'b0;
    if (pwr_loss && !retain) begin
      st_d = DTF_ST_IDLE;
      q_d = 1'b0;
      cnt_clr = 1'b1;
    end else if (!pwr_loss) begin
      case (mode)
        DTF_MODE_ON: begin
          if (!trg_e) begin
            st_d = DTF_ST_IDLE;
            q_d = 1'b0;
            cnt_clr = 1'b1;
          end else if (rise) begin
            st_d = DTF_ST_TIMING;
            cnt_clr = 1'b1;
          end else if (st_q == DTF_ST_TIMING && reached) begin
            st_d = DTF_ST_EXPIRED;
            q_d = 1'b1;
          end
        end
        DTF_MODE_OFF: begin
          if (clr_e) begin
            st_d = DTF_ST_IDLE;
            q_d = 1'b0;
            cnt_clr = 1'b1;
          end else if (trg_e) begin
            st_d = DTF_ST_IDLE;
            q_d = 1'b1;
            cnt_clr = 1'b1;
          end else if (fall) begin
            st_d = DTF_ST_TIMING;
            cnt_clr = 1'b1;
          end else if (st_q == DTF_ST_TIMING && reached) begin
            st_d = DTF_ST_EXPIRED;
            q_d = 1'b0;
          end
        end
        DTF_MODE_ONOFF: begin
          if (rise) begin
            phase_hi_d = 1'b1;
            st_d = DTF_ST_TIMING;
            cnt_clr = 1'b1;
          end else if (fall) begin
            phase_hi_d = 1'b0;
            st_d = DTF_ST_TIMING;
            cnt_clr = 1'b1;
          end else if (st_q == DTF_ST_TIMING && reached) begin
            st_d = DTF_ST_EXPIRED;
            q_d = phase_hi_q;
          end
        end
        DTF_MODE_LATCH: begin
          if (clr_e) begin
            st_d = DTF_ST_IDLE;
            q_d = 1'b0;
            cnt_clr = 1'b1;
          end else if (st_q == DTF_ST_IDLE && rise) begin
            st_d = DTF_ST_TIMING;
            cnt_clr = 1'b1;
          end else if (st_q == DTF_ST_TIMING && reached) begin
            st_d = DTF_ST_EXPIRED;
            q_d = 1'b1;
          end
        end
        default: begin
          st_d = DTF_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= DTF_ST_IDLE;
      q_q <= 1'b0;
      phase_hi_q <= 1'b0;
    end else begin
      st_q <= st_d;
      q_q <= q_d;
      phase_hi_q <= phase_hi_d;
    end
  end

  // Elapsed count; frozen at expiry and during retained power loss
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      elapsed_count_q <= '0;
    end else if (cnt_clr) begin
      elapsed_count_q <= '0;
    end else if (st_q == DTF_ST_TIMING && tick_q && !reached && !pwr_loss) begin
      elapsed_count_q <= elapsed_count_q + CW'(1);
    end
  end

  assign q_out = q_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule : dtf_delay_timer
`default_nettype wire

//--- design/dtf_pkg.sv
// Purpose: Types shared by the delay timer block
// Assumes: Constants come from dtf_defs.svh
// Notes: State codes are one-hot
package dtf_pkg;

  typedef enum logic [1:0] {
    DTF_MODE_ON = 2'h0,
    DTF_MODE_OFF = 2'h1,
    DTF_MODE_ONOFF = 2'h2,
    DTF_MODE_LATCH = 2'h3
  } dtf_mode_e;

  typedef enum logic [1:0] {
    DTF_TB_MS = 2'h0,
    DTF_TB_S = 2'h1,
    DTF_TB_MIN = 2'h2
  } dtf_tbase_e;

  typedef enum logic [1:0] {
    DTF_UNIT_S = 2'h0,
    DTF_UNIT_M = 2'h1,
    DTF_UNIT_H = 2'h2
  } dtf_unit_e;

  typedef enum logic [2:0] {
    DTF_ST_IDLE = 3'h1,
    DTF_ST_TIMING = 3'h2,
    DTF_ST_EXPIRED = 3'h4
  } dtf_state_e;

endpackage : dtf_pkg

//--- design/dtf_span_calc.sv
// Purpose: Turns a constant or a referenced value into a span of 10 ms ticks
// Assumes: Referenced value is a signed 32-bit actual value
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "dtf_defs.svh"

module dtf_span_calc
  import dtf_pkg::*;
#(
  parameter int CW = 26
) (
  input wire logic use_value,
  input wire logic [1:0] value_tb,
  input wire logic [1:0] const_unit,
  input wire logic [15:0] const_word,
  input wire logic signed [31:0] analog_value,
  output logic [CW-1:0] span_ticks
);

  logic [31:0] val_lim;
  logic [31:0] val_clamped;
  logic [31:0] val_ticks;
  logic [31:0] major;
  logic [31:0] minor;
  logic [31:0] minor_lim;
  logic [31:0] const_ticks;

  always_comb begin
    case (dtf_tbase_e'(value_tb))
      DTF_TB_MS: val_lim = `DTF_LIM_MS;
      DTF_TB_S: val_lim = `DTF_LIM_S;
      default: val_lim = `DTF_LIM_MIN;
    endcase
    // Out-of-range values snap to the nearest valid one
    if (analog_value < 0) begin
      val_clamped = 32'h0;
    end else if (32'(analog_value) > val_lim) begin
      val_clamped = val_lim;
    end else begin
      val_clamped = 32'(analog_value);
    end
    case (dtf_tbase_e'(value_tb))
      DTF_TB_MS: val_ticks = val_clamped / `DTF_MS_PER_TICK;
      DTF_TB_S: val_ticks = val_clamped * `DTF_TICKS_PER_S;
      default: val_ticks = val_clamped * `DTF_TICKS_PER_MIN;
    endcase
  end

  always_comb begin
    major = 32'(const_word[`DTF_SPAN_MAJOR_MSB:`DTF_SPAN_MAJOR_LSB]);
    minor = 32'(const_word[`DTF_SPAN_MINOR_MSB:`DTF_SPAN_MINOR_LSB]);
    minor_lim = (dtf_unit_e'(const_unit) == DTF_UNIT_S) ? `DTF_CONST_MINOR_MAX_S : `DTF_CONST_MINOR_MAX_MH;
    if (major > `DTF_CONST_MAJOR_MAX) begin
      major = `DTF_CONST_MAJOR_MAX;
    end
    if (minor > minor_lim) begin
      minor = minor_lim;
    end
    case (dtf_unit_e'(const_unit))
      DTF_UNIT_S: const_ticks = major * `DTF_TICKS_PER_S + minor;
      DTF_UNIT_M: const_ticks = (major * `DTF_S_PER_MIN + minor) * `DTF_TICKS_PER_S;
      default: const_ticks = (major * `DTF_S_PER_MIN + minor) * `DTF_TICKS_PER_MIN;
    endcase
  end

  assign span_ticks = use_value ? CW'(val_ticks) : CW'(const_ticks);

endmodule : dtf_span_calc
`default_nettype wire

//--- sim/dtf_delay_timer_properties.sv
// Purpose: Port-level checks for the delay timer
// Assumes: Control address and data arrive in one beat
// Notes: Bound to dtf_delay_timer
`timescale 1ns/1ps
`default_nettype none
`include "dtf_defs.svh"
module dtf_delay_timer_chk
  import dtf_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic trg,
  input wire logic clr,
  input wire logic pwr_loss,
  input wire logic q_out
);
  logic [11:0] ctrl_q;
  logic [1:0] mode;
  logic tg;
  logic cl;
  // Shadow of the control word
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                 && s_axi_awaddr == AW'(`DTF_OFF_CTRL)) begin
      ctrl_q <= s_axi_wdata[11:0];
    end
  end
  assign mode = ctrl_q[1:0];
  assign tg = trg ^ ctrl_q[2];
  assign cl = clr ^ ctrl_q[3];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  on_low_a: assert property (
    mode == DTF_MODE_ON && !tg |-> ##[1:2] !q_out) else $error("on-delay high, trigger low");
  on_rise_a: assert property (
    mode == DTF_MODE_ON && $rose(q_out) |-> $past(tg)) else $error("on-delay rose untriggered");
  off_rise_a: assert property (
    mode == DTF_MODE_OFF && $rose(tg) && !cl && !pwr_loss |-> ##[1:2] q_out) else $error("off-delay late");
  off_clear_a: assert property (
    mode == DTF_MODE_OFF && cl |-> ##[1:2] !q_out) else $error("off clear lost");
  latch_clear_a: assert property (
    mode == DTF_MODE_LATCH && cl |-> ##[1:2] !q_out) else $error("latch clear lost");
  latch_hold_a: assert property (
    mode == DTF_MODE_LATCH && q_out && !cl && !$past(cl) && !pwr_loss && !$past(pwr_loss) |=> q_out)
    else $error("latch dropped");
  onoff_high_a: assert property (
    mode == DTF_MODE_ONOFF && q_out && tg && $past(tg) && !pwr_loss |=> q_out) else $error("on/off fell");
  onoff_low_a: assert property (
    mode == DTF_MODE_ONOFF && !q_out && !tg && !$past(tg) |=> !q_out) else $error("on/off rose");
  wr_resp_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("late bvalid");
  rd_resp_a: assert property (
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid) else $error("late rvalid");
  aw_block_a: assert property (
    s_axi_bvalid |-> !s_axi_awready) else $error("awready in response");
endmodule : dtf_delay_timer_chk
bind dtf_delay_timer dtf_delay_timer_chk #(.AW(AW)) u_dtf_delay_timer_chk (.clk_sys, .rst_n, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .trg, .clr, .pwr_loss, .q_out);
`default_nettype wire

//--- sim/dtf_delay_timer_tb_top.sv
// Purpose: Self-checking bench for the delay timer
// Assumes: Tick shortened to 4 clocks
// Notes: Every scenario starts from reset
`timescale 1ns/1ps
`default_nettype none
`include "dtf_defs.svh"
module dtf_delay_timer_tb_top;
  import dtf_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic trg, clr, pwr_loss, q_out;
  logic signed [31:0] cmp_value, thr_value, amp_value, cnt_value;
  int error_cnt = 0;
  int checks_done = 0;
  always #12.5 clk_sys = ~clk_sys;
  dtf_delay_timer #(.TICK_CYCLES(4)) u_dtf_delay_timer (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .trg, .clr, .pwr_loss, .cmp_value, .thr_value, .amp_value, .cnt_value, .q_out);
  dtf_fb_model u_dtf_fb_model (.clk_sys, .trg, .clr, .pwr_loss, .cmp_value, .thr_value, .amp_value, .cnt_value);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic rst();
    go(0, 0, 0);
    rst_n <= 1'b0;
    cyc(4);
    rst_n <= 1'b1;
    cyc(1);
  endtask : rst
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
  endtask : rd
  // Wait for q_out level
  task automatic wq(input logic v, input int n);
    int i;
    i = 0;
    while (q_out !== v && i < n) begin
      @(posedge clk_sys);
      i++;
    end
    chk(32'(q_out), 32'(v));
  endtask : wq
  // q_out holds v for n cycles
  task automatic hq(input logic v, input int n);
    int b = 0;
    repeat (n) begin
      @(posedge clk_sys);
      if (q_out !== v) b++;
    end
    chk(b, 0);
  endtask : hq
  task automatic go(input logic t, input logic c, input logic p);
    u_dtf_fb_model.st(t, c, p);
  endtask : go
  task automatic t_regs();
    rst();
    rd(`DTF_OFF_CTRL, 32'h0, `DTF_RESP_OKAY);
    rd(`DTF_OFF_HIGH_SPAN, 32'h0, `DTF_RESP_OKAY);
    wr(`DTF_OFF_CTRL, 32'habcd_e5a4, `DTF_RESP_OKAY);
    rd(`DTF_OFF_CTRL, 32'h0000_05a4, `DTF_RESP_OKAY);
    wr(`DTF_OFF_LOW_SPAN, 32'h1234_6363, `DTF_RESP_OKAY);
    rd(`DTF_OFF_LOW_SPAN, 32'h0000_6363, `DTF_RESP_OKAY);
    wr(8'h20, 32'hffff_ffff, `DTF_RESP_SLVERR);
    rd(8'h20, 32'h0, `DTF_RESP_SLVERR);
    wr(`DTF_OFF_ELAPSED, 32'hffff_ffff, `DTF_RESP_OKAY);
    rd(`DTF_OFF_ELAPSED, 32'h0, `DTF_RESP_OKAY);
  endtask : t_regs
  task automatic t_on();
    rst();
    wr(`DTF_OFF_HIGH_SPAN, 32'h5, `DTF_RESP_OKAY);
    go(1, 0, 0);
    hq(0, 12);
    wq(1, 16);
    go(0, 0, 0);
    wq(0, 3);
    go(1, 0, 0);
    hq(0, 12);
    go(0, 0, 0);
    cyc(2);
    go(1, 0, 0);
    hq(0, 12);
    go(0, 0, 0);
  endtask : t_on
  task automatic t_off();
    rst();
    wr(`DTF_OFF_HIGH_SPAN, 32'h6, `DTF_RESP_OKAY);
    wr(`DTF_OFF_CTRL, 32'h1, `DTF_RESP_OKAY);
    go(1, 0, 0);
    wq(1, 3);
    go(0, 0, 0);
    hq(1, 12);
    go(1, 0, 0);
    cyc(1);
    go(0, 0, 0);
    hq(1, 16);
    wq(0, 16);
    go(1, 0, 0);
    cyc(2);
    go(0, 0, 0);
    cyc(4);
    go(0, 1, 0);
    wq(0, 3);
    go(1, 1, 0);
    hq(0, 4);
  endtask : t_off
  task automatic t_onoff();
    rst();
    wr(`DTF_OFF_HIGH_SPAN, 32'h4, `DTF_RESP_OKAY);
    wr(`DTF_OFF_LOW_SPAN, 32'h4, `DTF_RESP_OKAY);
    wr(`DTF_OFF_CTRL, 32'h2, `DTF_RESP_OKAY);
    go(1, 0, 0);
    hq(0, 10);
    go(0, 0, 0);
    cyc(2);
    go(1, 0, 0);
    hq(0, 10);
    wq(1, 12);
    go(0, 0, 0);
    hq(1, 10);
    go(1, 0, 0);
    cyc(2);
    go(0, 0, 0);
    hq(1, 10);
    wq(0, 12);
  endtask : t_onoff
  task automatic t_latch();
    rst();
    wr(`DTF_OFF_HIGH_SPAN, 32'h5, `DTF_RESP_OKAY);
    wr(`DTF_OFF_CTRL, 32'h3, `DTF_RESP_OKAY);
    go(1, 0, 0);
    cyc(1);
    go(0, 0, 0);
    hq(0, 12);
    go(1, 0, 0);
    cyc(1);
    go(0, 0, 0);
    wq(1, 10);
    hq(1, 20);
    go(0, 1, 0);
    wq(0, 3);
  endtask : t_latch
  task automatic t_pwr();
    rst();
    wr(`DTF_OFF_HIGH_SPAN, 32'h2, `DTF_RESP_OKAY);
    wr(`DTF_OFF_CTRL, 32'h13, `DTF_RESP_OKAY);
    go(1, 0, 0);
    cyc(1);
    go(0, 0, 0);
    wq(1, 16);
    go(0, 0, 1);
    hq(1, 4);
    go(0, 0, 0);
    wr(`DTF_OFF_CTRL, 32'h3, `DTF_RESP_OKAY);
    go(0, 0, 1);
    wq(0, 3);
  endtask : t_pwr
  task automatic t_inv();
    rst();
    wr(`DTF_OFF_HIGH_SPAN, 32'h2, `DTF_RESP_OKAY);
    wr(`DTF_OFF_CTRL, 32'h4, `DTF_RESP_OKAY);
    wq(1, 16);
    go(1, 0, 0);
    wq(0, 3);
    wr(`DTF_OFF_CTRL, 32'hb, `DTF_RESP_OKAY);
    go(0, 0, 0);
    cyc(1);
    go(1, 0, 0);
    hq(0, 16);
    go(0, 1, 0);
    cyc(1);
    go(1, 1, 0);
    wq(1, 16);
  endtask : t_inv
  task automatic t_src();
    for (int s = 0; s < 4; s++) begin
      rst();
      u_dtf_fb_model.sel(s, 40, -7);
      wr(`DTF_OFF_CTRL, (32'(s) << 10) | 32'h20, `DTF_RESP_OKAY);
      go(1, 0, 0);
      hq(0, 10);
      wq(1, 12);
    end
    rst();
    u_dtf_fb_model.sel(3, -5, 99999);
    wr(`DTF_OFF_CTRL, 32'hc20, `DTF_RESP_OKAY);
    go(1, 0, 0);
    wq(1, 4);
  endtask : t_src
  task automatic t_span();
    logic [11:0] cf [5] = '{12'h000, 12'h100, 12'h200, 12'hc60, 12'hca0};
    logic [15:0] sw [5] = '{16'h0102, 16'h0001, 16'h0001, 16'h0000, 16'h0000};
    int tk [5] = '{102, 100, 6000, 100, 6000};
    for (int i = 0; i < 5; i++) begin
      rst();
      u_dtf_fb_model.sel(3, 1, -7);
      wr(`DTF_OFF_HIGH_SPAN, 32'(sw[i]), `DTF_RESP_OKAY);
      wr(`DTF_OFF_CTRL, 32'(cf[i]), `DTF_RESP_OKAY);
      go(1, 0, 0);
      hq(0, tk[i] * 4 - 8);
      wq(1, 16);
    end
  endtask : t_span
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    t_regs();
    t_on();
    t_off();
    t_onoff();
    t_latch();
    t_pwr();
    t_inv();
    t_src();
    t_span();
    end_sim();
  end
  initial begin
    #2400000;
    error_cnt++;
    end_sim();
  end
endmodule : dtf_delay_timer_tb_top
`default_nettype wire

//--- sim/dtf_fb_model.sv
// Purpose: Neighbouring function blocks feeding the timer
// Assumes: Tasks are called just after a rising edge
// Notes: Actual values hold until changed
`timescale 1ns/1ps
`default_nettype none
module dtf_fb_model (
  input wire logic clk_sys,
  output logic trg,
  output logic clr,
  output logic pwr_loss,
  output logic signed [31:0] cmp_value,
  output logic signed [31:0] thr_value,
  output logic signed [31:0] amp_value,
  output logic signed [31:0] cnt_value
);
  logic signed [31:0] v_q [4];
  initial begin
    trg = 1'b0;
    clr = 1'b0;
    pwr_loss = 1'b0;
    v_q = '{32'sh0, 32'sh0, 32'sh0, 32'sh0};
  end
  assign cmp_value = v_q[0];
  assign thr_value = v_q[1];
  assign amp_value = v_q[2];
  assign cnt_value = v_q[3];
  task automatic st(input logic t, input logic c, input logic p);
    trg <= t;
    clr <= c;
    pwr_loss <= p;
  endtask : st
  // Chosen block shows a, all others b
  task automatic sel(input int s, input int a, input int b);
    for (int i = 0; i < 4; i++) begin
      v_q[i] <= (i == s) ? a : b;
    end
  endtask : sel
endmodule : dtf_fb_model
`default_nettype wire
